// ### shared/core_ops_pkg.sv
package core_ops_pkg;
   localparam int INSTR_W = 14;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int PC_W = 15;
   localparam int PC_LOW_W = 11;
   localparam int LATCH_W = 7;
   localparam int OPC_MSB = 13;
   localparam int OPC_LSB = 8;
   localparam int JUMP_LSB = 11;
   localparam int DEST_BIT = 7;
   localparam int LATCH_HI_MSB = 6;
   localparam int LATCH_HI_LSB = 3;
   localparam logic [5:0] OPC_INCREMENT_FILE = 6'h01;
   localparam logic [5:0] OPC_INCREMENT_SKIP = 6'h02;
   localparam logic [5:0] OPC_OR_FILE = 6'h03;
   localparam logic [5:0] OPC_SHIFT_LEFT = 6'h04;
   localparam logic [5:0] OPC_OR_LITERAL = 6'h05;
   localparam logic [2:0] OPC_JUMP = 3'h7;
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic CARRY_RST = 1'b0;
   localparam logic ZERO_RST = 1'b0;
   localparam logic [14:0] PC_RST = 15'h0000;

   typedef enum logic [2:0] {
      op_nop,
      op_increment_file,
      op_increment_skip_if_zero,
      op_or_accumulator_with_file,
      op_shift_left_file,
      op_or_literal_into_accumulator,
      op_jump
   } op_t;

   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_read = 3'b010,
      st_exec = 3'b100
   } state_t;

   typedef struct packed {
      op_t op;
      logic [6:0] addr;
      logic dest;
      logic [10:0] imm;
   } decoded_t;

   typedef struct packed {
      logic we;
      logic [6:0] addr;
      logic [7:0] data;
   } file_write_t;
endpackage : core_ops_pkg

// ### rtl/increment_or_shift_jump_ops.sv
`timescale 1ns/100ps
module increment_or_shift_jump_ops (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic instr_valid,
   input wire logic [13:0] instr,
   output logic instr_ready,
   input wire logic [6:0] program_counter_high_latch,
   output logic file_rd,
   output logic [6:0] file_raddr,
   input wire logic [7:0] file_rdata,
   output core_ops_pkg::file_write_t file_wr,
   output logic [7:0] acc,
   output logic carry,
   output logic zero,
   output logic pc_load,
   output logic [14:0] pc_value,
   output logic retired,
   output logic skipped,
   output logic unsupported
);

   function automatic core_ops_pkg::decoded_t decode(input logic [13:0] w);
      core_ops_pkg::decoded_t d;
      logic [5:0] opc;
      d.op = core_ops_pkg::op_nop;
      d.addr = w[6:0];
      d.dest = w[core_ops_pkg::DEST_BIT];
      d.imm = w[10:0];
      opc = w[core_ops_pkg::OPC_MSB:core_ops_pkg::OPC_LSB];
      if (w[13:core_ops_pkg::JUMP_LSB] == core_ops_pkg::OPC_JUMP) begin
         d.op = core_ops_pkg::op_jump;
      end else if (opc == core_ops_pkg::OPC_INCREMENT_FILE) begin
         d.op = core_ops_pkg::op_increment_file;
      end else if (opc == core_ops_pkg::OPC_INCREMENT_SKIP) begin
         d.op = core_ops_pkg::op_increment_skip_if_zero;
      end else if (opc == core_ops_pkg::OPC_OR_FILE) begin
         d.op = core_ops_pkg::op_or_accumulator_with_file;
      end else if (opc == core_ops_pkg::OPC_SHIFT_LEFT) begin
         d.op = core_ops_pkg::op_shift_left_file;
      end else if (opc == core_ops_pkg::OPC_OR_LITERAL) begin
         d.op = core_ops_pkg::op_or_literal_into_accumulator;
      end
      return d;
   endfunction : decode

   function automatic logic uses_file(input core_ops_pkg::op_t op);
      return (op == core_ops_pkg::op_increment_file) ||
             (op == core_ops_pkg::op_increment_skip_if_zero) ||
             (op == core_ops_pkg::op_or_accumulator_with_file) ||
             (op == core_ops_pkg::op_shift_left_file);
   endfunction : uses_file

   core_ops_pkg::state_t state_q;
   core_ops_pkg::decoded_t cur_q;
   core_ops_pkg::decoded_t dec;
   logic accept;
   logic discard_q;
   logic flushed_q;
   logic bad_q;
   logic [7:0] result;
   logic new_carry;
   logic writes_dest;
   logic sets_zero;

   assign accept = instr_valid && instr_ready;
   assign dec = decode(instr);

   always_comb begin
      result = acc;
      new_carry = carry;
      writes_dest = 1'b0;
      sets_zero = 1'b0;
      case (cur_q.op)
         core_ops_pkg::op_increment_file: begin
            result = 8'(file_rdata + 8'h01);
            writes_dest = 1'b1;
            sets_zero = 1'b1;
         end
         core_ops_pkg::op_increment_skip_if_zero: begin
            result = 8'(file_rdata + 8'h01);
            writes_dest = 1'b1;
         end
         core_ops_pkg::op_or_accumulator_with_file: begin
            result = acc | file_rdata;
            writes_dest = 1'b1;
            sets_zero = 1'b1;
         end
         core_ops_pkg::op_shift_left_file: begin
            result = {file_rdata[6:0], 1'b0};
            new_carry = file_rdata[7];
            writes_dest = 1'b1;
            sets_zero = 1'b1;
         end
         core_ops_pkg::op_or_literal_into_accumulator: begin
            result = acc | cur_q.imm[7:0];
            sets_zero = 1'b1;
         end
         default: begin
            result = acc;
         end
      endcase
   end

   // Sequencing: one pass from acceptance to retirement is one instruction cycle.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= core_ops_pkg::st_idle;
         instr_ready <= 1'b0;
         cur_q <= '0;
         flushed_q <= 1'b0;
         bad_q <= 1'b0;
         file_rd <= 1'b0;
         file_raddr <= 7'h00;
      end else begin
         file_rd <= 1'b0;
         case (state_q)
            core_ops_pkg::st_idle: begin
               instr_ready <= 1'b1;
               if (accept) begin
                  instr_ready <= 1'b0;
                  flushed_q <= discard_q;
                  bad_q <= 1'b0;
                  cur_q <= dec;
                  if (discard_q) begin
                     // The instruction behind a taken skip or jump runs as a no-op.
                     cur_q.op <= core_ops_pkg::op_nop;
                     state_q <= core_ops_pkg::st_exec;
                  end else if (uses_file(dec.op)) begin
                     file_rd <= 1'b1;
                     file_raddr <= dec.addr;
                     state_q <= core_ops_pkg::st_read;
                  end else begin
                     bad_q <= (dec.op == core_ops_pkg::op_nop);
                     state_q <= core_ops_pkg::st_exec;
                  end
               end
            end
            core_ops_pkg::st_read: begin
               state_q <= core_ops_pkg::st_exec;
            end
            core_ops_pkg::st_exec: begin
               instr_ready <= 1'b1;
               state_q <= core_ops_pkg::st_idle;
            end
            default: begin
               state_q <= core_ops_pkg::st_idle;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         acc <= core_ops_pkg::ACC_RST;
         carry <= core_ops_pkg::CARRY_RST;
         zero <= core_ops_pkg::ZERO_RST;
         file_wr <= '0;
      end else begin
         file_wr.we <= 1'b0;
         if (state_q == core_ops_pkg::st_exec) begin
            if (writes_dest && cur_q.dest == core_ops_pkg::DEST_FILE) begin
               file_wr.we <= 1'b1;
               file_wr.addr <= cur_q.addr;
               file_wr.data <= result;
            end else if (writes_dest || cur_q.op == core_ops_pkg::op_or_literal_into_accumulator) begin
               acc <= result;
            end
            if (sets_zero) begin
               zero <= (result == 8'h00);
            end
            carry <= new_carry;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         discard_q <= 1'b0;
         pc_load <= 1'b0;
         pc_value <= core_ops_pkg::PC_RST;
         retired <= 1'b0;
         skipped <= 1'b0;
         unsupported <= 1'b0;
      end else begin
         pc_load <= 1'b0;
         retired <= 1'b0;
         skipped <= 1'b0;
         unsupported <= 1'b0;
         if (state_q == core_ops_pkg::st_exec) begin
            retired <= 1'b1;
            skipped <= flushed_q;
            unsupported <= bad_q && !flushed_q;
            discard_q <= ((cur_q.op == core_ops_pkg::op_increment_skip_if_zero) &&
                          (result == 8'h00)) ||
                         (cur_q.op == core_ops_pkg::op_jump);
            if (cur_q.op == core_ops_pkg::op_jump) begin
               pc_load <= 1'b1;
               pc_value <= {program_counter_high_latch[core_ops_pkg::LATCH_HI_MSB:
                                                       core_ops_pkg::LATCH_HI_LSB],
                            cur_q.imm};
            end
         end
      end
   end

endmodule : increment_or_shift_jump_ops

// ### tb/increment_or_shift_jump_ops_props.sv
`timescale 1ns/100ps
module increment_or_shift_jump_ops_props (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic instr_valid,
   input wire logic [13:0] instr,
   input wire logic instr_ready,
   input wire logic [6:0] program_counter_high_latch,
   input wire logic file_rd,
   input wire logic [6:0] file_raddr,
   input wire logic [7:0] file_rdata,
   input wire core_ops_pkg::file_write_t file_wr,
   input wire logic [7:0] acc,
   input wire logic carry,
   input wire logic zero,
   input wire logic pc_load,
   input wire logic [14:0] pc_value,
   input wire logic retired,
   input wire logic skipped,
   input wire logic unsupported
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic tk;
   assign tk = instr_valid & instr_ready;
   ready_drop_a: assert property (tk |=> !instr_ready)
      else $error("ready stayed high after a take");
   read_addr_a: assert property (file_rd |-> file_raddr == $past(instr[6:0]))
      else $error("read address differs from operand");
   file_time_a: assert property (file_rd |-> ##2 retired)
      else $error("file op did not retire on time");
   jump_time_a: assert property (tk && instr[13:11] == core_ops_pkg::OPC_JUMP
      |-> ##2 (retired && (pc_load || skipped))) else $error("jump did not retire on time");
   jump_target_a: assert property (pc_load
      |-> pc_value == {$past(program_counter_high_latch[6:3]), $past(instr[10:0], 2)})
      else $error("bad jump target");
   flush_quiet_a: assert property (skipped
      |-> $stable(acc) && $stable(carry) && $stable(zero) && !file_wr.we)
      else $error("flushed slot changed state");
   skip_flags_a: assert property ($past(file_rd, 2)
      && $past(instr[13:8], 3) == core_ops_pkg::OPC_INCREMENT_SKIP
      |-> retired && $stable(carry) && $stable(zero)) else $error("skip increment moved a flag");
   shift_flags_a: assert property ($past(file_rd, 2)
      && $past(instr[13:8], 3) == core_ops_pkg::OPC_SHIFT_LEFT
      |-> carry == $past(file_rdata[7]) && zero == ($past(file_rdata[6:0]) == 7'h00))
      else $error("shift flags wrong");
   inc_write_a: assert property ($past(file_rd, 2)
      && $past(instr[13:7], 3) == {core_ops_pkg::OPC_INCREMENT_FILE, 1'b1}
      |-> file_wr.we && file_wr.data == $past(file_rdata) + 8'h01) else $error("bad file write");
   cover property (pc_load);
   cover property (skipped);
   cover property (file_wr.we);
endmodule : increment_or_shift_jump_ops_props

// ### tb/increment_or_shift_jump_ops_test.sv
`timescale 1ns/100ps
module increment_or_shift_jump_ops_test;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic instr_valid = 1'b0;
   logic [13:0] instr = 14'h0000;
   logic [6:0] program_counter_high_latch = 7'h5a;
   logic [7:0] file_rdata = 8'h00;
   logic instr_ready, file_rd, carry, zero, pc_load, retired, skipped, unsupported;
   logic [6:0] file_raddr;
   logic [7:0] acc;
   logic [14:0] pc_value;
   core_ops_pkg::file_write_t file_wr;
   int num_errors = 0;
   int samples_checked = 0;
   increment_or_shift_jump_ops u_increment_or_shift_jump_ops (
      .mclk(mclk), .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
      .instr_ready(instr_ready), .program_counter_high_latch(program_counter_high_latch),
      .file_rd(file_rd), .file_raddr(file_raddr), .file_rdata(file_rdata),
      .file_wr(file_wr), .acc(acc), .carry(carry), .zero(zero), .pc_load(pc_load),
      .pc_value(pc_value), .retired(retired), .skipped(skipped), .unsupported(unsupported)
   );
   initial forever #2.5 mclk = ~mclk;
   task automatic close_out();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Returns at the falling edge of the retire cycle, where the pulses are visible.
   task automatic run(input logic [13:0] w, input logic [7:0] rd);
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr <= w;
      file_rdata <= rd;
      @(negedge mclk);
      while (instr_ready !== 1'b1) @(negedge mclk);
      @(posedge mclk);
      instr_valid <= 1'b0;
      @(negedge mclk);
      while (retired !== 1'b1) @(negedge mclk);
   endtask : run
   task automatic t_or_lit();
      run({core_ops_pkg::OPC_OR_LITERAL, 8'h00}, 8'h00);
      chk({acc, 7'h00, zero}, 16'h0001);
      run({core_ops_pkg::OPC_OR_LITERAL, 8'h81}, 8'h00);
      chk({acc, 7'h00, zero}, 16'h8100);
   endtask : t_or_lit
   task automatic t_inc();
      run({core_ops_pkg::OPC_INCREMENT_FILE, 8'h7f}, 8'hff);
      chk({acc, 7'h00, zero}, 16'h0001);
      run({core_ops_pkg::OPC_INCREMENT_FILE, 8'hff}, 8'h41);
      chk(file_wr, 16'hff42);
      chk({acc, 7'h00, zero}, 16'h0000);
   endtask : t_inc
   task automatic t_shift_or();
      run({core_ops_pkg::OPC_SHIFT_LEFT, 8'h05}, 8'hc1);
      chk({acc, 6'h00, carry, zero}, 16'h8202);
      run({core_ops_pkg::OPC_SHIFT_LEFT, 8'h05}, 8'h80);
      chk({acc, 6'h00, carry, zero}, 16'h0003);
      run({core_ops_pkg::OPC_OR_FILE, 8'h05}, 8'h5a);
      chk({acc, 6'h00, carry, zero}, 16'h5a02);
   endtask : t_shift_or
   task automatic t_skip();
      run({core_ops_pkg::OPC_INCREMENT_SKIP, 8'h10}, 8'hff);
      chk({acc, 6'h00, carry, zero}, 16'h0002);
      run({core_ops_pkg::OPC_OR_LITERAL, 8'h01}, 8'h00);
      chk({acc, 6'h00, skipped, zero}, 16'h0002);
      run({core_ops_pkg::OPC_INCREMENT_SKIP, 8'h10}, 8'h0e);
      run({core_ops_pkg::OPC_OR_LITERAL, 8'h30}, 8'h00);
      chk({acc, 6'h00, skipped, zero}, 16'h3f00);
   endtask : t_skip
   task automatic t_jump();
      run({core_ops_pkg::OPC_JUMP, 11'h7ff}, 8'h00);
      chk({pc_load, pc_value}, 16'hdfff);
      chk({acc, 6'h00, carry, zero}, 16'h3f02);
      run({core_ops_pkg::OPC_OR_LITERAL, 8'hc0}, 8'h00);
      chk({acc, 7'h00, skipped}, 16'h3f01);
      // An unknown opcode retires as a no-op and flags itself.
      run(14'h0000, 8'h00);
      chk({acc, 6'h00, unsupported, zero}, 16'h3f02);
   endtask : t_jump
   initial begin
      #20000;
      num_errors++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      repeat (2) @(posedge mclk);
      t_or_lit();
      t_inc();
      t_shift_or();
      t_skip();
      t_jump();
      close_out();
   end
endmodule : increment_or_shift_jump_ops_test
bind increment_or_shift_jump_ops increment_or_shift_jump_ops_props u_increment_or_shift_jump_ops_props (
   .mclk(mclk), .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
   .instr_ready(instr_ready), .program_counter_high_latch(program_counter_high_latch),
   .file_rd(file_rd), .file_raddr(file_raddr), .file_rdata(file_rdata),
   .file_wr(file_wr), .acc(acc), .carry(carry), .zero(zero), .pc_load(pc_load),
   .pc_value(pc_value), .retired(retired), .skipped(skipped), .unsupported(unsupported)
);
